// >>> verilog/ccio_top.sv
`timescale 1ns/1ps
module ccio_top #(
    parameter int CYC_PER_MS = ccio_pkg::CYC_PER_MS,
    parameter int RO_DEPTH = ccio_pkg::RO_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ccio_pkg::N_IN-1:0] contact_in,
    input wire ccio_pkg::ccio_mode_t in_mode [ccio_pkg::N_IN],
    input wire ccio_pkg::ccio_tx_cfg_t tx_cfg [ccio_pkg::N_IN][ccio_pkg::N_COPY],
    input wire logic [9:0] tx_loss_s [ccio_pkg::N_IN],
    input wire logic msg_ready,
    input wire ccio_pkg::ccio_mode_t out_mode [ccio_pkg::N_OUT],
    input wire ccio_pkg::ccio_rx_cfg_t rx_cfg [ccio_pkg::N_OUT],
    input wire ccio_pkg::ccio_pkt_t pkt,
    input wire logic pkt_valid,
    input wire logic [ccio_pkg::N_OUT-1:0] api_relay_cmd,
    output ccio_pkg::ccio_msg_t msg_out,
    output logic msg_valid,
    output logic [ccio_pkg::N_IN-1:0] in_status,
    output logic [ccio_pkg::N_IN-1:0] tx_loss_alarm,
    output logic [ccio_pkg::N_OUT-1:0] relay_out,
    output logic [ccio_pkg::N_OUT-1:0] rx_receiving,
    output logic [ccio_pkg::N_OUT-1:0] rx_no_stream,
    output logic [ccio_pkg::N_OUT-1:0] rx_loss_alarm
);
    localparam int NI = ccio_pkg::N_IN;
    localparam int NC = ccio_pkg::N_COPY;

    logic [31:0] div;
    logic ms_tick;
    logic [3:0] smp_ms;
    logic [6:0] cnf_ms;
    logic [9:0] sec_ms;
    logic sample_tick;
    logic confirm_tick;
    logic s_tick;
    logic [NI-1:0] next_status;
    logic [NI-1:0] chg;
    logic [NI-1:0][NC-1:0] pend;
    logic found;
    logic [2:0] sel_i;
    logic [1:0] sel_c;
    logic take;

    // ************************************************************
    // Time base
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst || div == 32'(CYC_PER_MS - 1)) begin
            div <= 32'h0;
        end else begin
            div <= div + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= div == 32'(CYC_PER_MS - 1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            smp_ms <= 4'h0;
            cnf_ms <= 7'h00;
            sec_ms <= 10'h000;
        end else if (ms_tick) begin
            smp_ms <= smp_ms == ccio_pkg::SAMPLE_MS - 4'h1 ? 4'h0 : smp_ms + 4'h1;
            cnf_ms <= cnf_ms == ccio_pkg::CONFIRM_MS - 7'h01 ? 7'h00 : cnf_ms + 7'h01;
            sec_ms <= sec_ms == ccio_pkg::SEC_MS - 10'h001 ? 10'h000 : sec_ms + 10'h001;
        end
    end

    assign sample_tick = ms_tick && smp_ms == ccio_pkg::SAMPLE_MS - 4'h1;
    assign confirm_tick = ms_tick && cnf_ms == ccio_pkg::CONFIRM_MS - 7'h01;
    assign s_tick = ms_tick && sec_ms == ccio_pkg::SEC_MS - 10'h001;

    // ************************************************************
    // Input sampling
    // ************************************************************
    // Status keeps updating with streams disabled, so management can still read it.
    always_comb begin
        for (int i = 0; i < NI; i++) begin
            next_status[i] = ccio_pkg::ccio_apply(in_mode[i], contact_in[i]);
        end
    end
    assign chg = next_status ^ in_status;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            in_status <= '0;
        end else if (sample_tick) begin
            in_status <= next_status;
        end
    end

    // ************************************************************
    // Stream sender
    // ************************************************************
    always_comb begin
        found = 1'b0;
        sel_i = 3'h0;
        sel_c = 2'h0;
        for (int i = 0; i < NI; i++) begin
            for (int c = 0; c < NC; c++) begin
                if (!found && pend[i][c] && tx_cfg[i][c].en) begin
                    found = 1'b1;
                    sel_i = 3'(i);
                    sel_c = 2'(c);
                end
            end
        end
    end
    assign take = found && (!msg_valid || msg_ready);

    for (genvar gi = 0; gi < NI; gi++) begin : g_in
        for (genvar gc = 0; gc < NC; gc++) begin : g_copy
            // A new event in the cycle the slot is sent keeps the slot pending.
            always_ff @(posedge clk_sys) begin
                if (sys_rst || !tx_cfg[gi][gc].en) begin
                    pend[gi][gc] <= 1'b0;
                end else if ((sample_tick && chg[gi]) || confirm_tick) begin
                    pend[gi][gc] <= 1'b1;
                end else if (take && sel_i == 3'(gi) && sel_c == 2'(gc)) begin
                    pend[gi][gc] <= 1'b0;
                end
            end
        end

        logic [9:0] idle_s;
        always_ff @(posedge clk_sys) begin
            if (sys_rst || (msg_valid && msg_ready && msg_out.input_idx == 3'(gi))) begin
                idle_s <= 10'h000;
            end else if (s_tick && idle_s != ccio_pkg::LOSS_S_MAX) begin
                idle_s <= idle_s + 10'h001;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                tx_loss_alarm[gi] <= 1'b0;
            end else begin
                tx_loss_alarm[gi] <= (tx_cfg[gi][0].en || tx_cfg[gi][1].en || tx_cfg[gi][2].en)
                    && idle_s >= tx_loss_s[gi];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            msg_valid <= 1'b0;
            msg_out <= '0;
        end else if (take) begin
            msg_valid <= 1'b1;
            msg_out <= '{input_idx: sel_i, copy: sel_c, dst_ip: tx_cfg[sel_i][sel_c].dst_ip,
                dst_port: tx_cfg[sel_i][sel_c].dst_port, state: in_status[sel_i]};
        end else if (msg_ready) begin
            msg_valid <= 1'b0;
        end
    end

    // ************************************************************
    // Relay receivers
    // ************************************************************
    for (genvar go = 0; go < ccio_pkg::N_OUT; go++) begin : g_out
        ccio_rx_chan #(
            .RO_DEPTH(RO_DEPTH)
        ) u_rx (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .cfg(rx_cfg[go]),
            .mode(out_mode[go]),
            .api_cmd(api_relay_cmd[go]),
            .pkt(pkt),
            .pkt_valid(pkt_valid),
            .ms_tick(ms_tick),
            .s_tick(s_tick),
            .relay(relay_out[go]),
            .receiving(rx_receiving[go]),
            .no_stream(rx_no_stream[go]),
            .loss_alarm(rx_loss_alarm[go])
        );
    end

    sequence s_stall;
        msg_valid && !msg_ready;
    endsequence

    a_msg_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_stall |=> msg_valid && $stable(msg_out))
        else $error("message changed while stalled");
    sequence s_change_armed;
        sample_tick && chg[0] && tx_cfg[0][0].en && msg_ready ##1 tx_cfg[0][0].en [*2];
    endsequence

    a_change_sent: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_change_armed |-> ##[0:30] (msg_valid && msg_out.input_idx == 3'h0))
        else $error("change not sent promptly");
    a_force_status: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sample_tick && in_mode[0] == ccio_pkg::CCIO_FORCE_OFF |=> !in_status[0])
        else $error("forced inactive input reads active");
    a_sample_gap: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sample_tick |=> !sample_tick [*8])
        else $error("samples too close together");
    a_tx_alarm_en: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tx_loss_alarm[1] |-> $past(tx_cfg[1][0].en || tx_cfg[1][1].en || tx_cfg[1][2].en))
        else $error("alarm on idle input");
endmodule // ccio_top

// >>> verilog/ccio_pkg.sv
// How it works
// - Eight contact inputs and four relay outputs each have their own mode, enable and addresses.
// - Every contact input feeds three outgoing streams, each with its own destination.
// - Every contact input is sampled one hundred times per second.
// - A sampled change is queued for sending at once, keeping contact-to-relay delay under 20 ms.
// - The present input state is also sent every 100 ms as a confirmation, with no extra coding.
// - Relays open on reset, and on a lost stream in pass and invert modes.
// - Inputs and outputs each have pass, invert, force-active and force-inactive modes.
// - A relay follows either the control command or the state of its received stream.
// - Clearing a stream enable stops only that stream; the contact stays readable and drivable.
// - A link works only with the sender aimed at the receiver's address and local port.
// - The receiver declares its stream lost after the fail delay (0 to 10000 ms, default 300).
// - Sender and receiver raise a link-loss alarm after a timeout in seconds (default 10).
// - A nonzero source port filter admits only that sending port; zero turns filtering off.
// - The receiver reorders out-of-sequence packets in a buffer of configurable depth.
// - Each output reports whether its enabled receiver is getting its stream or getting nothing.
package ccio_pkg;

    localparam int N_IN = 8;
    localparam int N_OUT = 4;
    localparam int N_COPY = 3;
    localparam int RO_DEPTH_DEF = 8;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int SAMPLE_RATE_HZ = 100;
    localparam logic [3:0] SAMPLE_MS = 4'(MS_PER_S / SAMPLE_RATE_HZ);
    localparam logic [6:0] CONFIRM_MS = 7'h64;
    localparam logic [9:0] SEC_MS = 10'(MS_PER_S);
    localparam logic [13:0] FAIL_MS_DEF = 14'h012c;
    localparam logic [13:0] FAIL_MS_MAX = 14'h2710;
    localparam logic [9:0] LOSS_S_DEF = 10'h00a;
    localparam logic [9:0] LOSS_S_MAX = 10'h3e8;
    localparam logic [15:0] SRC_FILTER_OFF = 16'h0000;

    typedef enum logic [1:0] {
        CCIO_PASS,
        CCIO_INVERT,
        CCIO_FORCE_ON,
        CCIO_FORCE_OFF
    } ccio_mode_t;

    typedef struct packed {
        logic en;
        logic [31:0] dst_ip;
        logic [15:0] dst_port;
    } ccio_tx_cfg_t;

    typedef struct packed {
        logic en;
        logic [31:0] src_ip;
        logic [15:0] local_port;
        logic [15:0] src_port_filter;
        logic [13:0] fail_ms;
        logic [9:0] loss_s;
    } ccio_rx_cfg_t;

    typedef struct packed {
        logic [2:0] input_idx;
        logic [1:0] copy;
        logic [31:0] dst_ip;
        logic [15:0] dst_port;
        logic state;
    } ccio_msg_t;

    typedef struct packed {
        logic [31:0] src_ip;
        logic [15:0] src_port;
        logic [15:0] dst_port;
        logic [7:0] seq;
        logic state;
    } ccio_pkt_t;

    function automatic logic ccio_apply(input ccio_mode_t mode, input logic raw);
        unique case (mode)
            CCIO_PASS: ccio_apply = raw;
            CCIO_INVERT: ccio_apply = ~raw;
            CCIO_FORCE_ON: ccio_apply = 1'b1;
            CCIO_FORCE_OFF: ccio_apply = 1'b0;
        endcase
    endfunction

endpackage

// >>> verilog/ccio_rx_chan.sv
`timescale 1ns/1ps
module ccio_rx_chan #(
    parameter int RO_DEPTH = ccio_pkg::RO_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire ccio_pkg::ccio_rx_cfg_t cfg,
    input wire ccio_pkg::ccio_mode_t mode,
    input wire logic api_cmd,
    input wire ccio_pkg::ccio_pkt_t pkt,
    input wire logic pkt_valid,
    input wire logic ms_tick,
    input wire logic s_tick,
    output logic relay,
    output logic receiving,
    output logic no_stream,
    output logic loss_alarm
);
    localparam int IW = $clog2(RO_DEPTH);

    logic acc;
    logic [7:0] exp_seq;
    logic synced;
    logic [7:0] diff;
    logic [RO_DEPTH-1:0] buf_vld;
    logic [RO_DEPTH-1:0] buf_st;
    logic stream_state;
    logic [13:0] ms_cnt;
    logic [9:0] s_cnt;
    logic lost;
    logic src;

    // ************************************************************
    // Packet acceptance
    // ************************************************************
    assign acc = pkt_valid && cfg.en && pkt.src_ip == cfg.src_ip
        && pkt.dst_port == cfg.local_port
        && (cfg.src_port_filter == ccio_pkg::SRC_FILTER_OFF
        || pkt.src_port == cfg.src_port_filter);
    assign diff = pkt.seq - exp_seq;

    // ************************************************************
    // Reorder buffer
    // ************************************************************
    // Packets far ahead of the window force a resync rather than stalling forever.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !cfg.en) begin
            buf_vld <= '0;
            buf_st <= '0;
            exp_seq <= 8'h00;
            synced <= 1'b0;
            stream_state <= 1'b0;
        end else begin
            if (buf_vld[exp_seq[IW-1:0]]) begin
                stream_state <= buf_st[exp_seq[IW-1:0]];
                buf_vld[exp_seq[IW-1:0]] <= 1'b0;
                exp_seq <= exp_seq + 8'h01;
            end
            if (acc) begin
                if (!synced || (diff >= 8'(RO_DEPTH) && !diff[7])) begin
                    buf_vld <= '0;
                    buf_vld[pkt.seq[IW-1:0]] <= 1'b1;
                    buf_st[pkt.seq[IW-1:0]] <= pkt.state;
                    exp_seq <= pkt.seq;
                    synced <= 1'b1;
                end else if (diff < 8'(RO_DEPTH)
                    && !(diff == 8'h00 && buf_vld[exp_seq[IW-1:0]])) begin
                    // A repeat of the entry being drained would linger as a stale future entry.
                    buf_vld[pkt.seq[IW-1:0]] <= 1'b1;
                    buf_st[pkt.seq[IW-1:0]] <= pkt.state;
                end
            end
        end
    end

    // ************************************************************
    // Supervision timers
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !cfg.en) begin
            ms_cnt <= ccio_pkg::FAIL_MS_MAX;
        end else if (acc) begin
            ms_cnt <= 14'h0000;
        end else if (ms_tick && ms_cnt != ccio_pkg::FAIL_MS_MAX) begin
            ms_cnt <= ms_cnt + 14'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !cfg.en) begin
            s_cnt <= 10'h000;
        end else if (acc) begin
            s_cnt <= 10'h000;
        end else if (s_tick && s_cnt != ccio_pkg::LOSS_S_MAX) begin
            s_cnt <= s_cnt + 10'h001;
        end
    end

    assign lost = cfg.en && !acc && ms_cnt >= cfg.fail_ms;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            no_stream <= 1'b0;
            receiving <= 1'b0;
            loss_alarm <= 1'b0;
        end else begin
            no_stream <= lost;
            receiving <= cfg.en && !lost;
            loss_alarm <= cfg.en && !acc && s_cnt >= cfg.loss_s;
        end
    end

    // ************************************************************
    // Relay drive
    // ************************************************************
    assign src = cfg.en ? stream_state : api_cmd;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            relay <= 1'b0;
        end else if ((mode == ccio_pkg::CCIO_PASS || mode == ccio_pkg::CCIO_INVERT) && lost) begin
            relay <= 1'b0;
        end else begin
            relay <= ccio_pkg::ccio_apply(mode, src);
        end
    end

    a_lost_opens: assert property (@(posedge clk_sys) disable iff (sys_rst)
        lost && mode == ccio_pkg::CCIO_PASS |=> !relay && no_stream)
        else $error("relay not opened on lost stream");
    a_force_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
        mode == ccio_pkg::CCIO_FORCE_ON && !lost |=> relay)
        else $error("forced relay not closed");
    a_packet_revives: assert property (@(posedge clk_sys) disable iff (sys_rst)
        acc |=> receiving && !no_stream && !loss_alarm)
        else $error("accepted packet did not clear loss");
    a_filter_blocks: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pkt_valid && cfg.src_port_filter != 16'h0000 && pkt.src_port != cfg.src_port_filter
        && ms_cnt >= cfg.fail_ms && cfg.en |=> no_stream)
        else $error("filtered packet revived stream");
    a_api_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !cfg.en && mode == ccio_pkg::CCIO_PASS |=> relay == $past(api_cmd))
        else $error("relay not following command");
endmodule // ccio_rx_chan

// >>> verification/ccio_far_codec.sv
`timescale 1ns/1ps
// ************************************************
// Remote codec: sinks status messages, sources packets.
// ************************************************
module ccio_far_codec (
    input wire logic clk_sys,
    input wire ccio_pkg::ccio_msg_t msg_out,
    input wire logic msg_valid,
    input wire logic stall,
    input wire logic [3:0] lag,
    output logic msg_ready,
    output ccio_pkg::ccio_pkt_t pkt,
    output logic pkt_valid
);
    ccio_pkg::ccio_msg_t got [$];
    logic [3:0] wait_cnt;
    initial begin
        msg_ready = 1'b0;
        pkt = '0;
        pkt_valid = 1'b0;
        wait_cnt = 4'h0;
    end
    // Acceptance is judged at the falling edge, where the values seen by the
    // next rising edge are already settled; this avoids a race with the design.
    always begin
        @(negedge clk_sys);
        if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
            got.push_back(msg_out);
            wait_cnt = lag;
        end else if (wait_cnt != 4'h0) begin
            wait_cnt = wait_cnt - 4'h1;
        end
        @(posedge clk_sys);
        #1;
        msg_ready = !stall && wait_cnt == 4'h0;
    end
    // The idle bus carries the inverted last packet so stale data never looks valid.
    task automatic send(input ccio_pkg::ccio_pkt_t p);
        @(posedge clk_sys);
        #1;
        pkt = p;
        pkt_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        pkt_valid = 1'b0;
        pkt = ~p;
    endtask
endmodule // ccio_far_codec

// >>> verification/tb_ccio_top.sv
`timescale 1ns/1ps
// ************************************************
// Testbench for the contact closure unit.
// ************************************************
module tb_ccio_top;
    localparam logic [31:0] PEER_IP = 32'h0a000002;
    localparam logic [15:0] LPORT = 16'h1388;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] contact_in = 8'h00;
    ccio_pkg::ccio_mode_t in_mode [8];
    ccio_pkg::ccio_tx_cfg_t tx_cfg [8][3];
    logic [9:0] tx_loss_s [8];
    ccio_pkg::ccio_mode_t out_mode [4];
    ccio_pkg::ccio_rx_cfg_t rx_cfg [4];
    logic [3:0] api_relay_cmd = 4'h0;
    logic stall = 1'b0;
    logic [3:0] lag = 4'h2;
    logic msg_ready;
    logic msg_valid;
    logic pkt_valid;
    ccio_pkg::ccio_msg_t msg_out;
    ccio_pkg::ccio_pkt_t pkt;
    logic [7:0] in_status;
    logic [7:0] tx_loss_alarm;
    logic [3:0] relay_out;
    logic [3:0] rx_receiving;
    logic [3:0] rx_no_stream;
    logic [3:0] rx_loss_alarm;
    int num_errors = 0;
    int total_checks = 0;

    always #50 clk_sys = ~clk_sys;

    // A 10-cycle millisecond keeps every timeout short enough to simulate.
    ccio_top #(.CYC_PER_MS(10), .RO_DEPTH(8)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .contact_in(contact_in), .in_mode(in_mode),
        .tx_cfg(tx_cfg), .tx_loss_s(tx_loss_s), .msg_ready(msg_ready), .out_mode(out_mode),
        .rx_cfg(rx_cfg), .pkt(pkt), .pkt_valid(pkt_valid), .api_relay_cmd(api_relay_cmd),
        .msg_out(msg_out), .msg_valid(msg_valid), .in_status(in_status),
        .tx_loss_alarm(tx_loss_alarm), .relay_out(relay_out), .rx_receiving(rx_receiving),
        .rx_no_stream(rx_no_stream), .rx_loss_alarm(rx_loss_alarm)
    );

    ccio_far_codec far (
        .clk_sys(clk_sys), .msg_out(msg_out), .msg_valid(msg_valid), .stall(stall),
        .lag(lag), .msg_ready(msg_ready), .pkt(pkt), .pkt_valid(pkt_valid)
    );

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    function automatic logic mexp(input int m, input logic raw);
        case (m)
            0: return raw;
            1: return ~raw;
            2: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic ccio_pkg::ccio_rx_cfg_t rx(input logic [15:0] filt);
        return '{1'b1, PEER_IP, LPORT, filt, 14'h0005, 10'h002};
    endfunction

    function automatic ccio_pkg::ccio_pkt_t pk(input logic [31:0] ip, input logic [15:0] sp,
            input logic [7:0] s, input logic st);
        return '{ip, sp, LPORT, s, st};
    endfunction

    task automatic t_in_modes();
        tx_cfg[0][0] = '{1'b1, PEER_IP, LPORT};
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 2; r++) begin
                in_mode[0] = ccio_pkg::ccio_mode_t'(m[1:0]);
                contact_in[0] = r[0];
                repeat (110) if (in_status[0] !== mexp(m, r[0])) tick(1);
                check(in_status[0], mexp(m, r[0]), "input mode");
            end
        end
        tick(10);
        check({far.got.size() > 0, far.got[$].state}, 2'b10, "input stream state");
        tx_cfg[0][0].en = 1'b0;
    endtask

    task automatic t_msgs();
        logic [3:0] hit;
        logic [15:0] dst;
        logic [31:0] dip;
        hit = 4'h0;
        dst = 16'h0000;
        dip = 32'h00000000;
        tx_cfg[1][0] = '{1'b1, 32'h0a000010, 16'h0400};
        tx_cfg[1][2] = '{1'b1, 32'h0a000012, 16'h0402};
        tick(250);
        far.got.delete();
        contact_in[1] = 1'b1;
        repeat (200) if (!(far.got.size() > 0 && far.got[$].copy === 2'h2
            && far.got[$].state === 1'b1)) tick(1);
        check(far.got[$].state, 1'b1, "change latency");
        foreach (far.got[i]) begin
            if (far.got[i].state === 1'b1) hit[far.got[i].copy] = 1'b1;
            if (far.got[i].copy === 2'h2) dst = far.got[i].dst_port;
            if (far.got[i].copy === 2'h2) dip = far.got[i].dst_ip;
        end
        check(dip, 32'h0a000012, "copy address");
        check(hit, 4'b0101, "copies sent");
        check(dst, 16'h0402, "copy destination");
        check(far.got[0].input_idx, 3'h1, "input index");
        far.got.delete();
        tick(1100);
        check(far.got.size() >= 2 && far.got.size() <= 4, 1'b1, "confirm rate");
    endtask

    task automatic t_api_relay();
        for (int m = 0; m < 4; m++) begin
            for (int a = 0; a < 2; a++) begin
                out_mode[0] = ccio_pkg::ccio_mode_t'(m[1:0]);
                api_relay_cmd[0] = a[0];
                tick(5);
                check(relay_out[0], mexp(m, a[0]), "relay mode");
            end
        end
    endtask

    task automatic t_rx_stream();
        rx_cfg[1] = rx(16'h0000);
        tick(3);
        check({rx_no_stream[1], rx_receiving[1], relay_out[1]}, 3'b100, "idle rx");
        far.send(pk(PEER_IP, 16'h2000, 8'h00, 1'b1));
        tick(4);
        check({rx_no_stream[1], rx_receiving[1], relay_out[1]}, 3'b011, "stream up");
        tick(25);
        check(rx_no_stream[1], 1'b0, "early loss");
        tick(50);
        check({rx_no_stream[1], rx_receiving[1], relay_out[1]}, 3'b100, "lost");
        rx_cfg[1].src_port_filter = 16'h2001;
        far.send(pk(PEER_IP, 16'h2000, 8'h01, 1'b1));
        tick(4);
        check(rx_receiving[1], 1'b0, "filtered port");
        far.send(pk(PEER_IP, 16'h2001, 8'h01, 1'b1));
        tick(4);
        check(relay_out[1], 1'b1, "filter match");
        far.send(pk(32'h0a000003, 16'h2001, 8'h02, 1'b0));
        tick(3);
        check(relay_out[1], 1'b1, "foreign source");
        far.send(pk(PEER_IP, 16'h2001, 8'h03, 1'b0));
        far.send(pk(PEER_IP, 16'h2001, 8'h02, 1'b1));
        tick(6);
        check({rx_receiving[1], relay_out[1]}, 2'b10, "reorder");
        out_mode[3] = ccio_pkg::CCIO_FORCE_ON;
        rx_cfg[3] = rx(16'h0000);
        rx_cfg[1].en = 1'b0;
        api_relay_cmd[1] = 1'b1;
        tick(80);
        check({rx_no_stream[3], relay_out[3]}, 2'b11, "forced relay");
        check(relay_out[1], 1'b1, "api after disable");
    endtask

    task automatic t_loss();
        stall = 1'b1;
        rx_cfg[2] = rx(16'h0000);
        tx_loss_s[1] = 10'h002;
        tick(9000);
        check({tx_loss_alarm[1], rx_loss_alarm[2]}, 2'b00, "early alarm");
        repeat (22000) if ({tx_loss_alarm[1], rx_loss_alarm[2]} !== 2'b11) tick(1);
        check({tx_loss_alarm[1], rx_loss_alarm[2]}, 2'b11, "loss alarm");
        stall = 1'b0;
    endtask

    task automatic t_reset();
        check(relay_out, 4'ha, "relays before reset");
        sys_rst = 1'b1;
        tick(2);
        check({relay_out, msg_valid, rx_receiving, rx_loss_alarm, tx_loss_alarm}, 21'h000000,
            "mid-run reset");
        sys_rst = 1'b0;
        tick(2);
        check(relay_out, 4'ha, "relays after reset");
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 8; i++) begin
            in_mode[i] = ccio_pkg::CCIO_PASS;
            tx_loss_s[i] = 10'h00a;
            for (int j = 0; j < 3; j++) tx_cfg[i][j] = '0;
        end
        for (int i = 0; i < 4; i++) begin
            out_mode[i] = ccio_pkg::CCIO_PASS;
            rx_cfg[i] = '0;
        end
        tick(16);
        check({relay_out, msg_valid, rx_no_stream}, 9'h000, "reset outputs");
        sys_rst = 1'b0;
        tick(2);
        check(relay_out, 4'h0, "relays open");
        t_in_modes();
        t_msgs();
        t_api_relay();
        t_rx_stream();
        t_loss();
        t_reset();
        summarize();
    end

    initial begin
        #(80000 * 100);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
endmodule // tb_ccio_top
